// *** shared/sbrg_params.svh ***
// Register map, field positions, reset values and prescale figures of the baud generator
`ifndef SBRG_PARAMS_SVH
`define SBRG_PARAMS_SVH

// ==================================================
// Register offsets
`define SBRG_ADDR_RX_CTRL       8'h18
`define SBRG_ADDR_TX_CTRL       8'h98
`define SBRG_ADDR_DIVISOR       8'h99

// ==================================================
// Reset values
`define SBRG_TX_CTRL_RESET      8'h02
`define SBRG_RX_CTRL_RESET      8'h00
`define SBRG_DIVISOR_RESET      8'h00

// ==================================================
// Field positions and writable masks
`define SBRG_BIT_MASTER         7
`define SBRG_BIT_SYNC           4
`define SBRG_BIT_HIGH_SPEED     2
`define SBRG_BIT_SHIFT_EMPTY    1
`define SBRG_TX_WR_MASK         8'hf5
`define SBRG_RX_WR_MASK         8'hf0

// ==================================================
// Final prescale per mode
`define SBRG_PRE_ASYNC_LOW      7'h40
`define SBRG_PRE_ASYNC_HIGH     7'h10
`define SBRG_PRE_SYNC           7'h04

`endif

// *** shared/sbrg_pkg.sv ***
// Types shared by the baud generator modules
package sbrg_pkg;

    // ==================================================
    // Operating modes
    typedef enum logic [1:0] {
        SBRG_ASYNC_LOW,
        SBRG_ASYNC_HIGH,
        SBRG_SYNC
    } sbrg_mode_t;

    // ==================================================
    // Module state records
    typedef struct packed {
        logic [7:0] tx_ctrl;
        logic [7:0] rx_ctrl;
        logic       shift_empty;
        logic [2:0] rx_stat;
        logic [7:0] divisor;
        logic       restart;
        logic [6:0] prescale;
        logic       bit_tick;
        logic [7:0] rdata;
    } sbrg_top_state_t;

    typedef struct packed {
        logic [7:0] count;
        logic       tick;
    } sbrg_timer_state_t;

    typedef struct packed {
        logic       meta;
        logic       sync;
        logic [2:0] samples;
        logic       level;
    } sbrg_samp_state_t;

endpackage

// *** shared/sbrg_link_if.sv ***
// Signals between the baud generator top and its timer and sampler
`timescale 1ns/1ps
interface sbrg_link_if;
    logic [7:0] divisor;
    logic       restart;
    logic       tick;
    logic       rx_pin;
    logic       sample_en;
    logic       rx_level;

    modport top     (output divisor, output restart, output rx_pin, output sample_en,
                     input tick, input rx_level);
    modport timer   (input divisor, input restart, output tick);
    modport sampler (input rx_pin, input sample_en, output rx_level);
endinterface

// *** hw/sbrg_timer.sv ***
// Free-running 8-bit reload timer of the baud generator
`timescale 1ns/1ps
module sbrg_timer (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Link to top
    sbrg_link_if.timer link
);
    import sbrg_pkg::*;

    sbrg_timer_state_t st;
    sbrg_timer_state_t next_st;

    // ==================================================
    // Count down, reload on zero or on restart
    always_comb begin
        next_st      = st;
        next_st.tick = 1'b0;
        if (link.restart) begin
            next_st.count = link.divisor;
        end else if (st.count == 8'h00) begin
            next_st.count = link.divisor;
            next_st.tick  = 1'b1;
        end else begin
            next_st.count = st.count - 8'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign link.tick = st.tick;

    // ==================================================
    // Checks
    logic [8:0] gap;
    logic       gap_clean;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap       <= 9'h000;
            gap_clean <= 1'b0;
        end else begin
            gap       <= st.tick ? 9'h000 : gap + 9'h001;
            gap_clean <= link.restart ? 1'b0 : (st.tick ? 1'b1 : gap_clean);
        end
    end

    chk_restart_load: assert property (@(posedge clk) disable iff (rst)
        link.restart |=> (st.count == $past(link.divisor)) && !st.tick)
        else $error("timer did not reload on restart");
    chk_timer_period: assert property (@(posedge clk) disable iff (rst)
        (st.tick && gap_clean && !link.restart && !$past(link.restart)) |-> gap == {1'b0, link.divisor})
        else $error("timer period differs from divisor plus one");
    chk_tick_single: assert property (@(posedge clk) disable iff (rst)
        (st.tick && link.divisor != 8'h00 && !link.restart) |=> !st.tick)
        else $error("timer tick longer than one cycle");
endmodule

// *** hw/sbrg_sampler.sv ***
// Receive pin synchroniser with three-sample majority vote
`timescale 1ns/1ps
module sbrg_sampler (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Link to top
    sbrg_link_if.sampler link
);
    import sbrg_pkg::*;

    sbrg_samp_state_t st;
    sbrg_samp_state_t next_st;

    function automatic logic vote(input logic [2:0] s);
        vote = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    // ==================================================
    // Two-stage synchroniser, then vote on each sample strobe
    always_comb begin
        next_st      = st;
        next_st.meta = link.rx_pin;
        next_st.sync = st.meta;
        if (link.sample_en) begin
            next_st.samples = {st.samples[1:0], st.sync};
            next_st.level   = vote({st.samples[1:0], st.sync});
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '{meta: 1'b1, sync: 1'b1, samples: 3'h7, level: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign link.rx_level = st.level;

    // ==================================================
    // Checks
    sequence s_sample;
        link.sample_en;
    endsequence

    chk_vote_result: assert property (@(posedge clk) disable iff (rst)
        s_sample |=> st.level == vote(st.samples) && st.samples[2:1] == $past(st.samples[1:0]))
        else $error("level is not the majority of three samples");
    chk_pin_path: assert property (@(posedge clk) disable iff (rst)
        s_sample |=> st.samples[0] == $past(st.sync, 1) && st.sync == $past(link.rx_pin, 2))
        else $error("sample did not pass both synchroniser stages");
endmodule

// *** hw/sbrg_top.sv ***
// Baud rate generator top: register port, reload timer, final prescale and receive sampler
//
// Contract
// - One dedicated 8-bit generator serves both asynchronous and synchronous modes.
// - The timer period is set by the software-written divisor register.
// - In asynchronous mode the high-speed select bit also sets the rate.
// - In synchronous mode the high-speed select bit is ignored.
// - The rate equations hold only for a master using its internal clock.
// - Asynchronous low speed gives oscillator over 64 times divisor plus one.
// - Asynchronous high speed gives oscillator over 16 times divisor plus one.
// - Synchronous mode gives oscillator over 4 times divisor plus one.
// - The divisor is an unsigned value from 0 to 255.
// - Any write to the divisor reloads the timer and clears the prescale so the new rate starts at once.
// - The receive pin is sampled three times and the majority gives its level.
// - In asynchronous mode the timer tick runs at 16 or 64 times the bit rate.
// - Clearing the synchronous mode bit selects asynchronous operation.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "sbrg_params.svh"
module sbrg_top (
    // Clock and reset
    input  wire  logic       clk,
    input  wire  logic       rst,
    // Register port
    input  wire  logic [7:0] addr,
    input  wire  logic [7:0] wdata,
    input  wire  logic       wr,
    input  wire  logic       rd,
    output logic       [7:0] rdata,
    // Receive pin
    input  wire  logic       receive_data_pin,
    output logic             rx_level,
    // Status from shift logic
    input  wire  logic       shift_empty,
    input  wire  logic [2:0] rx_status,
    // Ticks and controls to shift logic
    output logic             oversample_tick,
    output logic             bit_tick,
    output logic       [7:0] tx_control,
    output logic       [7:0] rx_control
);
    import sbrg_pkg::*;

    // ==================================================
    // Decoders
    function automatic sbrg_mode_t mode_of(input logic [7:0] ctrl);
        if (ctrl[`SBRG_BIT_SYNC]) begin
            mode_of = SBRG_SYNC;
        end else if (ctrl[`SBRG_BIT_HIGH_SPEED]) begin
            mode_of = SBRG_ASYNC_HIGH;
        end else begin
            mode_of = SBRG_ASYNC_LOW;
        end
    endfunction

    function automatic logic [6:0] modulus_of(input sbrg_mode_t m);
        unique case (m)
            SBRG_ASYNC_LOW: begin
                modulus_of = `SBRG_PRE_ASYNC_LOW;
            end
            SBRG_ASYNC_HIGH: begin
                modulus_of = `SBRG_PRE_ASYNC_HIGH;
            end
            SBRG_SYNC: begin
                modulus_of = `SBRG_PRE_SYNC;
            end
            default: begin
                modulus_of = `SBRG_PRE_ASYNC_LOW;
            end
        endcase
    endfunction

    function automatic logic internal_clock(input logic [7:0] ctrl);
        internal_clock = !ctrl[`SBRG_BIT_SYNC] || ctrl[`SBRG_BIT_MASTER];
    endfunction

    // ==================================================
    // State and submodules
    sbrg_top_state_t st;
    sbrg_top_state_t next_st;
    sbrg_link_if     link ();

    sbrg_timer u_timer (
        .clk  (clk),
        .rst  (rst),
        .link (link.timer)
    );

    sbrg_sampler u_sampler (
        .clk  (clk),
        .rst  (rst),
        .link (link.sampler)
    );

    assign link.divisor   = st.divisor;
    assign link.restart   = st.restart;
    assign link.rx_pin    = receive_data_pin;
    assign link.sample_en = link.tick;

    // ==================================================
    // Register access and prescale
    logic       wr_tx;
    logic       wr_rx;
    logic       wr_div;
    sbrg_mode_t mode;
    logic [6:0] modulus;

    assign wr_tx   = wr && (addr == `SBRG_ADDR_TX_CTRL);
    assign wr_rx   = wr && (addr == `SBRG_ADDR_RX_CTRL);
    assign wr_div  = wr && (addr == `SBRG_ADDR_DIVISOR);
    assign mode    = mode_of(st.tx_ctrl);
    assign modulus = modulus_of(mode);

    always_comb begin
        next_st             = st;
        next_st.restart     = wr_div;
        next_st.bit_tick    = 1'b0;
        next_st.rdata       = 8'h00;
        next_st.shift_empty = shift_empty;
        next_st.rx_stat     = rx_status;
        if (wr_tx) begin
            next_st.tx_ctrl = wdata & `SBRG_TX_WR_MASK;
        end
        if (wr_rx) begin
            next_st.rx_ctrl = wdata & `SBRG_RX_WR_MASK;
        end
        if (wr_div) begin
            next_st.divisor = wdata;
        end
        if (wr_div || st.restart) begin
            next_st.prescale = 7'h00;
        end else if (link.tick) begin
            if (st.prescale + 7'h01 >= modulus) begin
                next_st.prescale = 7'h00;
                next_st.bit_tick = internal_clock(st.tx_ctrl);
            end else begin
                next_st.prescale = st.prescale + 7'h01;
            end
        end
        if (rd) begin
            unique case (addr)
                `SBRG_ADDR_TX_CTRL: begin
                    next_st.rdata = {st.tx_ctrl[7:2], st.shift_empty, st.tx_ctrl[0]};
                end
                `SBRG_ADDR_RX_CTRL: begin
                    next_st.rdata = {st.rx_ctrl[7:4], 1'b0, st.rx_stat};
                end
                `SBRG_ADDR_DIVISOR: begin
                    next_st.rdata = st.divisor;
                end
                default: begin
                    next_st.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '{tx_ctrl:     `SBRG_TX_CTRL_RESET & `SBRG_TX_WR_MASK,
                    rx_ctrl:     `SBRG_RX_CTRL_RESET,
                    shift_empty: 1'b1,
                    rx_stat:     3'h0,
                    divisor:     `SBRG_DIVISOR_RESET,
                    restart:     1'b0,
                    prescale:    7'h00,
                    bit_tick:    1'b0,
                    rdata:       8'h00};
        end else begin
            st <= next_st;
        end
    end

    // ==================================================
    // Outputs
    assign rdata           = st.rdata;
    assign rx_level        = link.rx_level;
    assign oversample_tick = link.tick;
    assign bit_tick        = st.bit_tick;
    assign tx_control      = st.tx_ctrl;
    assign rx_control      = st.rx_ctrl;

    // ==================================================
    // Check helpers
    logic [7:0] ticks_seen;
    logic       rate_clean;
    logic [8:0] cyc_since;
    logic       since_valid;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ticks_seen  <= 8'h00;
            rate_clean  <= 1'b0;
            cyc_since   <= 9'h000;
            since_valid <= 1'b0;
        end else begin
            if (st.restart) begin
                since_valid <= 1'b0;
            end else if (link.tick) begin
                since_valid <= 1'b1;
            end
            if (st.bit_tick) begin
                ticks_seen <= {7'h00, link.tick};
            end else begin
                ticks_seen <= ticks_seen + {7'h00, link.tick};
            end
            if (wr_tx || wr_div || st.restart) begin
                rate_clean <= 1'b0;
            end else if (st.bit_tick) begin
                rate_clean <= 1'b1;
            end
            cyc_since <= link.tick ? 9'h000 : cyc_since + 9'h001;
        end
    end

    // ==================================================
    // Checks
    sequence s_bit_done;
        st.bit_tick && rate_clean;
    endsequence

    sequence s_div_write;
        wr_div ##1 st.restart;
    endsequence

    sequence s_read(logic [7:0] a);
        rd && !wr && addr == a;
    endsequence

    property p_rate(sbrg_mode_t m, logic [7:0] n);
        @(posedge clk) disable iff (rst)
        (s_bit_done and (mode == m)) |-> ticks_seen == n;
    endproperty

    chk_rate_async_low: assert property (p_rate(SBRG_ASYNC_LOW, 8'h40))
        else $error("low speed prescale is not 64");
    chk_rate_async_high: assert property (p_rate(SBRG_ASYNC_HIGH, 8'h10))
        else $error("high speed prescale is not 16");
    chk_rate_sync: assert property (p_rate(SBRG_SYNC, 8'h04))
        else $error("synchronous prescale is not 4");

    chk_sync_no_speed: assert property (@(posedge clk) disable iff (rst)
        (s_bit_done and st.tx_ctrl[`SBRG_BIT_SYNC] && st.tx_ctrl[`SBRG_BIT_HIGH_SPEED])
        |-> ticks_seen == 8'h04)
        else $error("high speed select altered synchronous rate");

    chk_speed_select: assert property (@(posedge clk) disable iff (rst)
        (s_bit_done and !st.tx_ctrl[`SBRG_BIT_SYNC])
        |-> ticks_seen == (st.tx_ctrl[`SBRG_BIT_HIGH_SPEED] ? 8'h10 : 8'h40))
        else $error("high speed select did not set asynchronous rate");

    chk_async_select: assert property (@(posedge clk) disable iff (rst)
        (wr_tx && !wdata[`SBRG_BIT_SYNC]) |=> mode != SBRG_SYNC)
        else $error("clearing sync bit did not select asynchronous mode");

    chk_slave_silent: assert property (@(posedge clk) disable iff (rst)
        (st.tx_ctrl[`SBRG_BIT_SYNC] && !st.tx_ctrl[`SBRG_BIT_MASTER]) |=> !st.bit_tick)
        else $error("bit tick produced without internal clock");

    chk_tick_origin: assert property (@(posedge clk) disable iff (rst)
        st.bit_tick |-> $past(link.tick) && $past(st.prescale) + 7'h01 >= $past(modulus))
        else $error("bit tick not aligned to timer tick");

    chk_write_restart: assert property (@(posedge clk) disable iff (rst)
        (s_div_write ##0 !wr_div) |=> st.prescale == 7'h00 && link.divisor == $past(wdata, 2))
        else $error("divisor write did not restart the generator");

    chk_first_tick: assert property (@(posedge clk) disable iff (rst)
        s_div_write |-> ##[1:257] link.tick)
        else $error("no tick within one new period after divisor write");

    chk_div_readback: assert property (@(posedge clk) disable iff (rst)
        (rd && addr == `SBRG_ADDR_DIVISOR && !wr) |=> rdata == $past(st.divisor))
        else $error("divisor read back wrong");

    chk_read_window: assert property (@(posedge clk) disable iff (rst)
        !rd |=> rdata == 8'h00)
        else $error("read data present outside its cycle");

    chk_tick_spacing: assert property (@(posedge clk) disable iff (rst)
        (link.tick && !st.restart && !$past(st.restart)) |-> ##1 !link.tick [*1] or
        (link.divisor == 8'h00))
        else $error("tick spacing wrong");

    chk_one_generator: assert property (@(posedge clk) disable iff (rst)
        (since_valid && cyc_since > {1'b0, st.divisor}) |-> (st.restart || $past(st.restart) || $past(wr_div)))
        else $error("timer overran divisor period");

    chk_tx_write_mask: assert property (@(posedge clk) disable iff (rst)
        wr_tx |=> st.tx_ctrl == ($past(wdata) & `SBRG_TX_WR_MASK))
        else $error("transmit control write mask wrong");

    chk_rx_write_mask: assert property (@(posedge clk) disable iff (rst)
        wr_rx |=> st.rx_ctrl == ($past(wdata) & `SBRG_RX_WR_MASK))
        else $error("receive control write mask wrong");

    chk_div_write: assert property (@(posedge clk) disable iff (rst)
        wr_div |=> st.divisor == $past(wdata))
        else $error("divisor write not stored");

    chk_tx_hold: assert property (@(posedge clk) disable iff (rst)
        !wr_tx |=> $stable(st.tx_ctrl))
        else $error("transmit control changed without a write");

    chk_rx_hold: assert property (@(posedge clk) disable iff (rst)
        !wr_rx |=> $stable(st.rx_ctrl))
        else $error("receive control changed without a write");

    chk_div_hold: assert property (@(posedge clk) disable iff (rst)
        !wr_div |=> $stable(st.divisor))
        else $error("divisor changed without a write");

    chk_restart_pulse: assert property (@(posedge clk) disable iff (rst)
        wr_div |=> st.restart)
        else $error("divisor write gave no restart");

    chk_restart_origin: assert property (@(posedge clk) disable iff (rst)
        st.restart |-> $past(wr_div))
        else $error("restart without a divisor write");

    chk_bit_single: assert property (@(posedge clk) disable iff (rst)
        st.bit_tick |=> !st.bit_tick)
        else $error("bit tick longer than one cycle");

    chk_bit_master: assert property (@(posedge clk) disable iff (rst)
        st.bit_tick |-> internal_clock($past(st.tx_ctrl)))
        else $error("bit tick without internal clock");

    chk_prescale_bound: assert property (@(posedge clk) disable iff (rst)
        st.prescale < `SBRG_PRE_ASYNC_LOW)
        else $error("prescale count out of range");

    chk_tx_readback: assert property (@(posedge clk) disable iff (rst)
        s_read(`SBRG_ADDR_TX_CTRL) |=>
        rdata == {$past(st.tx_ctrl[7:2]), $past(st.shift_empty), $past(st.tx_ctrl[0])})
        else $error("transmit control read back wrong");

    chk_rx_readback: assert property (@(posedge clk) disable iff (rst)
        s_read(`SBRG_ADDR_RX_CTRL) |=> rdata == {$past(st.rx_ctrl[7:4]), 1'b0, $past(st.rx_stat)})
        else $error("receive control read back wrong");

    chk_status_sample: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> st.rx_stat == $past(rx_status) && st.shift_empty == $past(shift_empty))
        else $error("status inputs not sampled");

endmodule

// *** tb/sbrg_shift_model.sv ***
// Shift logic model that consumes the bit tick and reports status
`timescale 1ns/1ps
module sbrg_shift_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // From generator
    input  wire logic       bit_tick,
    input  wire logic [7:0] rx_control,
    // Line level from bench
    input  wire logic       line_level,
    // To generator
    output logic            shift_empty,
    output logic      [2:0] rx_status,
    output logic            receive_data_pin
);
    logic [2:0] count;

    // ==================================================
    // Counts bit ticks only while continuous receive is on
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= 3'h0;
        end else if (bit_tick && rx_control[4]) begin
            count <= count + 3'h1;
        end
    end

    assign rx_status        = count;
    assign shift_empty      = ~count[0];
    assign receive_data_pin = line_level;
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the baud generator
`timescale 1ns/1ps
`include "sbrg_params.svh"
module testbench;
    logic       clk, rst, wr, rd, line_level;
    logic [7:0] addr, wdata, rdata, tx_control, rx_control;
    logic       receive_data_pin, rx_level, shift_empty;
    logic       oversample_tick, bit_tick;
    logic [2:0] rx_status;
    int         num_errors, comparisons, k, n, i;
    logic [7:0] mtx [5] = '{8'h00, 8'h04, 8'h04, 8'h90, 8'h94};
    logic [7:0] mdv [5] = '{8'h02, 8'h00, 8'h05, 8'hff, 8'h01};
    int         mpre[5] = '{64, 16, 16, 4, 4};

    // ==================================================
    // Design and shift model
    sbrg_top uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .receive_data_pin(receive_data_pin), .rx_level(rx_level), .shift_empty(shift_empty),
        .rx_status(rx_status), .oversample_tick(oversample_tick), .bit_tick(bit_tick),
        .tx_control(tx_control), .rx_control(rx_control));
    sbrg_shift_model u_model (.clk(clk), .rst(rst), .bit_tick(bit_tick), .rx_control(rx_control),
        .line_level(line_level), .shift_empty(shift_empty), .rx_status(rx_status),
        .receive_data_pin(receive_data_pin));

    // ==================================================
    // Clock and watchdog
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #(50 * 60000);
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        report_and_stop();
    end

    // ==================================================
    // Tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        chk({8'h00, rdata}, {8'h00, exp}, "read data");
    endtask

    // Cycles between two successive ticks of the chosen output
    task automatic gap(input bit use_bit, output int g);
        int w;
        w = 0;
        g = 0;
        do begin @(negedge clk); w++; end
        while (((use_bit ? bit_tick : oversample_tick) !== 1'b1) && w < 5000);
        do begin @(negedge clk); g++; end
        while (((use_bit ? bit_tick : oversample_tick) !== 1'b1) && g < 5000);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ==================================================
    // Main sequence
    initial begin
        num_errors = 0;
        comparisons = 0;
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        line_level = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        // Reset values and unmapped read
        rd_chk(`SBRG_ADDR_TX_CTRL, `SBRG_TX_CTRL_RESET);
        rd_chk(`SBRG_ADDR_RX_CTRL, `SBRG_RX_CTRL_RESET);
        rd_chk(`SBRG_ADDR_DIVISOR, `SBRG_DIVISOR_RESET);
        rd_chk(8'h55, 8'h00);
        chk({7'h00, rx_level}, 16'h0001, "rx level idle");
        chk({tx_control, rx_control}, {`SBRG_TX_CTRL_RESET & `SBRG_TX_WR_MASK, `SBRG_RX_CTRL_RESET}, "control reset");
        // Writable masks, unmapped write, full divisor range
        wr_reg(`SBRG_ADDR_TX_CTRL, 8'hff);
        wr_reg(`SBRG_ADDR_RX_CTRL, 8'hef);
        wr_reg(`SBRG_ADDR_DIVISOR, 8'hff);
        wr_reg(8'h55, 8'h00);
        rd_chk(`SBRG_ADDR_TX_CTRL, 8'hf7);
        rd_chk(`SBRG_ADDR_RX_CTRL, 8'he0);
        rd_chk(`SBRG_ADDR_DIVISOR, 8'hff);
        chk({tx_control, rx_control}, 16'hf5e0, "control ports");
        wr_reg(`SBRG_ADDR_RX_CTRL, 8'h00);
        // Tick periods for every mode
        for (i = 0; i < 5; i++) begin
            wr_reg(`SBRG_ADDR_TX_CTRL, mtx[i]);
            wr_reg(`SBRG_ADDR_DIVISOR, mdv[i]);
            @(posedge clk);
            gap(1'b0, n);
            chk(n[15:0], 16'(mdv[i]) + 16'h1, "oversample period");
            gap(1'b1, n);
            chk(n[15:0], 16'(mpre[i] * (mdv[i] + 1)), "bit period");
        end
        // Sync slave makes no bit ticks
        wr_reg(`SBRG_ADDR_TX_CTRL, 8'h10);
        wr_reg(`SBRG_ADDR_DIVISOR, 8'h00);
        k = 0;
        repeat (300) begin
            @(negedge clk);
            if (bit_tick === 1'b1) k++;
        end
        chk(k[15:0], 16'h0000, "slave bit ticks");
        // Divisor write restarts a long period at once
        wr_reg(`SBRG_ADDR_TX_CTRL, 8'h00);
        wr_reg(`SBRG_ADDR_DIVISOR, 8'hff);
        repeat (20) @(posedge clk);
        wr_reg(`SBRG_ADDR_DIVISOR, 8'h02);
        repeat (2) @(negedge clk);
        k = 0;
        while (oversample_tick !== 1'b1 && k < 300) begin
            @(negedge clk);
            k++;
        end
        chk({15'h0000, k <= 4}, 16'h0001, "restart delay");
        // Status readback while the model runs and then freezes
        wr_reg(`SBRG_ADDR_DIVISOR, 8'h00);
        wr_reg(`SBRG_ADDR_RX_CTRL, 8'h10);
        repeat (200) @(posedge clk);
        wr_reg(`SBRG_ADDR_RX_CTRL, 8'h00);
        repeat (2) @(posedge clk);
        rd_chk(`SBRG_ADDR_RX_CTRL, {5'h00, rx_status});
        rd_chk(`SBRG_ADDR_TX_CTRL, {6'h00, shift_empty, 1'b0});
        // Majority vote: single low sample is rejected, steady levels pass
        @(posedge clk);
        line_level <= 1'b0;
        @(posedge clk);
        line_level <= 1'b1;
        k = 0;
        repeat (8) begin
            @(negedge clk);
            if (rx_level !== 1'b1) k++;
        end
        chk(k[15:0], 16'h0000, "glitch rejected");
        @(posedge clk);
        line_level <= 1'b0;
        repeat (8) @(negedge clk);
        chk({7'h00, rx_level}, 16'h0000, "steady low");
        @(posedge clk);
        line_level <= 1'b1;
        repeat (2) @(posedge clk);
        line_level <= 1'b0;
        k = 0;
        repeat (8) begin
            @(negedge clk);
            if (rx_level === 1'b1) k++;
        end
        chk({15'h0000, k > 0}, 16'h0001, "two high samples win");
        report_and_stop();
    end
endmodule
